//--- tb/scb_link_chk.sv
// checker for the word link between the controller end and the meter end
// assumes it sits beside the link interface and sees its plain signals
`timescale 1ns/1ps
`default_nettype none
`include "scb_defs.svh"
module scb_link_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata
);
  logic [15:0] gap_cnt_reg;
  logic [2:0] tpres_reg;

  // cycles since the last request, saturating so a long idle never wraps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_reg <= 16'h0000;
      tpres_reg <= 3'h0;
    end else begin
      if (req_valid) gap_cnt_reg <= 16'h0001;
      else if (gap_cnt_reg != 16'hFFFF) gap_cnt_reg <= gap_cnt_reg + 16'h0001;
      if (req_valid && req_write && req_addr == `SCB_A_TPRES) tpres_reg <= req_wdata[2:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_rsp_follows; req_valid |=> rsp_valid; endproperty
  a_rsp_follows: assert property (p_rsp_follows)
    else $error("request without response");
  property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("response longer than one cycle");
  // the silence between frames shows up as request spacing on the word link
  property p_req_gap; req_valid |-> gap_cnt_reg >= 16'(`SCB_GAP_CYCLES); endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("requests closer than the frame silence");
  property p_algo_const;
    req_valid && !req_write && req_addr == `SCB_A_ALGO |=> rsp_rdata == `SCB_ALGO_ECDSA;
  endproperty
  a_algo_const: assert property (p_algo_const)
    else $error("algorithm word not constant");
  property p_version;
    req_valid && !req_write && req_addr == `SCB_A_VERSION |=> rsp_rdata == `SCB_VERSION_1_0;
  endproperty
  a_version: assert property (p_version)
    else $error("format version word wrong");
  property p_status_code;
    req_valid && !req_write && req_addr == `SCB_A_STATUS |=>
      rsp_rdata inside {[16'h0000:16'h0002], 16'h000F, [16'h0080:16'h0085], [16'h00F3:16'h00FF]};
  endproperty
  a_status_code: assert property (p_status_code)
    else $error("status word outside the code set");
  property p_tpres_readback;
    req_valid && !req_write && req_addr == `SCB_A_TPRES |=> rsp_rdata[2:0] == tpres_reg;
  endproperty
  a_tpres_readback: assert property (p_tpres_readback)
    else $error("presentation select reads back wrong");
  property p_mapped_ok;
    req_valid && req_addr inside {[`SCB_A_CMD:`SCB_A_END_LAYOUT]} |=> !rsp_err;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped address answered with error");
  property p_unmapped_err;
    req_valid && !(req_addr inside {[`SCB_A_CMD:`SCB_A_END_LAYOUT]}) |=> rsp_err;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped address answered without error");
endmodule
`default_nettype wire

//--- tb/signing_control_register_bank_test.sv
// self-checking bench: controller end and meter end joined by the link interface
// assumes short second and minute counts so timeouts fit in the run
`timescale 1ns/1ps
`default_nettype none
`include "scb_defs.svh"
module signing_control_register_bank_test;
  import scb_pkg::*;
  logic sys_clk, rst_n, charge_active, eng_busy, eng_done, op_valid, op_write;
  logic op_ready, op_done, op_err, er, cmd_strobe, time_load, sig_base64, adj_strobe;
  logic totals_clear, fw_screen_on;
  logic [7:0] eng_result, letter;
  logic [15:0] in_msg_len, out_msg_len, sig_len, op_addr, op_wdata, op_rdata, rd, v;
  logic [15:0] cmd_word, utc_offset, adj_seconds, backlight, row2_mode, end_layout, sync_state;
  logic [31:0] unix_time, custom_label, tset;
  logic [63:0] custom_text;
  logic [2:0] time_utc_sel, tp;
  logic [7:0] letters [5] = '{8'h45, 8'h43, 8'h54, 8'h66, 8'h42};
  int error_cnt, n_checks, n_cmd, n_time, n_clr, n_adj, seed, i;

  scb_link_if link (.sys_clk(sys_clk), .rst_n(rst_n));
  scb_meter_end #(.SECOND_CYCLES(32'h0000_0014), .MINUTE_CYCLES(32'h0000_0032)) i_scb_meter_end (
    .link(link), .charge_active(charge_active), .eng_busy(eng_busy), .eng_done(eng_done),
    .eng_result(eng_result), .in_msg_len(in_msg_len), .out_msg_len(out_msg_len),
    .sig_len(sig_len), .cmd_strobe(cmd_strobe), .cmd_word(cmd_word), .time_load(time_load),
    .unix_time(unix_time), .utc_offset(utc_offset), .time_utc_sel(time_utc_sel),
    .sig_base64(sig_base64), .adj_strobe(adj_strobe), .adj_seconds(adj_seconds),
    .totals_clear(totals_clear), .fw_screen_on(fw_screen_on), .backlight(backlight),
    .row2_mode(row2_mode), .custom_text(custom_text), .custom_label(custom_label),
    .end_layout(end_layout), .sync_state(sync_state));
  scb_ctrl_end i_scb_ctrl_end (.link(link), .op_valid(op_valid), .op_write(op_write),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_ready(op_ready), .op_done(op_done),
    .op_err(op_err), .op_rdata(op_rdata));
  scb_link_chk i_scb_link_chk (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(link.req_valid),
    .req_write(link.req_write), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
    .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err), .rsp_rdata(link.rsp_rdata));

  // 10 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // pulse counters, so one-cycle strobes are never missed between polls
  always @(posedge sys_clk) begin
    if (cmd_strobe === 1'b1) n_cmd++;
    if (time_load === 1'b1) n_time++;
    if (totals_clear === 1'b1) n_clr++;
    if (adj_strobe === 1'b1) n_adj++;
  end

  // expected status after a command word, with time already set
  function automatic logic [15:0] cmd_exp(input logic [7:0] c, input logic chg);
    case (c)
      8'h42, 8'h69: return chg ? `SCB_ST_BAD_STATE : `SCB_ST_BUSY;
      8'h66: return `SCB_ST_BUSY;
      8'h45, 8'h4C, 8'h52, 8'h41, 8'h50, 8'h43, 8'h58, 8'h54, 8'h53, 8'h72, 8'h68:
        return chg ? `SCB_ST_BUSY : `SCB_ST_BAD_STATE;
      default: return `SCB_ST_BAD_CMD;
    endcase
  endfunction

  task automatic end_of_test;
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access through the controller end; the link gap makes each take ~3343 cycles
  task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d);
    int k;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_write <= w;
    op_addr <= a;
    op_wdata <= d;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    for (k = 0; k < 4000 && op_done !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (k == 4000) begin
      error_cnt++;
      $display("[ERR] op_done expected 1 seen timeout");
      end_of_test();
    end else begin
      rd = op_rdata;
      er = op_err;
    end
  endtask

  // main sequence; one access per step keeps the run near 90k cycles
  initial begin
    seed = 32'h17B5;
    rst_n = 1'b0;
    {charge_active, eng_busy, eng_done, op_valid, op_write} = 5'h00;
    {eng_result, op_addr, op_wdata} = 40'h0;
    in_msg_len = 16'($random(seed));
    out_msg_len = 16'($random(seed));
    sig_len = 16'($random(seed));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("time_utc_sel", 3'h0, time_utc_sel);
    chk("op_ready", 1'b1, op_ready);
    // stored display words come out of reset cleared
    chk("display words", 64'h0, {backlight, row2_mode, custom_label});
    op(1'b0, `SCB_A_STATUS, 16'h0000); chk("status", `SCB_ST_UNINIT, rd);
    op(1'b0, `SCB_A_TPRES, 16'h0000); chk("tpres", 3'h0, rd[2:0]);
    tp = 3'($random(seed));
    op(1'b1, `SCB_A_TPRES, {13'h0000, tp}); chk("time_utc_sel", tp, time_utc_sel);
    tset = $random(seed);
    op(1'b1, `SCB_A_TIME_HI, tset[31:16]); chk("time_load", 0, n_time);
    op(1'b1, `SCB_A_TIME_LO, tset[15:0]);
    chk("unix_time", tset, unix_time);
    chk("time_load", 1, n_time);
    op(1'b0, `SCB_A_STATUS, 16'h0000); chk("status", `SCB_ST_IDLE, rd);
    v = 16'($random(seed));
    op(1'b1, `SCB_A_TZ, v); chk("utc_offset", v, utc_offset);
    op(1'b1, `SCB_A_SIG_FMT, 16'h0001); chk("sig_base64", 1'b1, sig_base64);
    // a write to a read-only word is refused and reported
    op(1'b1, `SCB_A_ALGO, v);
    op(1'b0, `SCB_A_STATUS, 16'h0000); chk("status", `SCB_ST_BAD_CMD, rd);
    op(1'b0, `SCB_A_ALGO, 16'h0000); chk("algo", `SCB_ALGO_ECDSA, rd);
    op(1'b0, `SCB_A_VERSION, 16'h0000); chk("version", 16'h0100, rd);
    op(1'b1, `SCB_A_CLEAR, 16'h0001); chk("totals_clear", 1, n_clr);
    op(1'b0, `SCB_A_IN_LEN, 16'h0000); chk("in_len", in_msg_len, rd);
    // charging: time is locked, one fine adjust only
    @(posedge sys_clk);
    charge_active <= 1'b1;
    op(1'b1, `SCB_A_TIME_HI, ~tset[31:16]); chk("unix_time", tset, unix_time);
    op(1'b0, `SCB_A_STATUS, 16'h0000); chk("status", `SCB_ST_BAD_STATE, rd);
    op(1'b1, `SCB_A_ADJUST, 16'hFFFD); chk("adj_seconds", 16'hFFFD, adj_seconds);
    op(1'b1, `SCB_A_ADJUST, 16'h0001); chk("adj_strobe", 1, n_adj);
    letter = letters[$unsigned($random(seed)) % 5];
    op(1'b1, `SCB_A_CMD, {letter, 8'h00});
    chk("cmd_word", {letter, 8'h00}, cmd_word);
    chk("cmd_strobe", (cmd_exp(letter, 1'b1) == `SCB_ST_BUSY) ? 1 : 0, n_cmd);
    op(1'b0, `SCB_A_STATUS, 16'h0000); chk("status", cmd_exp(letter, 1'b1), rd);
    v = 16'h00F3 + 16'($unsigned($random(seed)) % 13);
    @(posedge sys_clk);
    eng_done <= 1'b1;
    eng_result <= v[7:0];
    @(posedge sys_clk);
    eng_done <= 1'b0;
    op(1'b0, `SCB_A_STATUS, 16'h0000); chk("status", v, rd);
    op(1'b1, 16'hB7E5, v); chk("op_err", 1'b1, er);
    // sync drops one short minute after being written
    op(1'b1, `SCB_A_SYNC_TMO, 16'h0001);
    op(1'b1, `SCB_A_SYNC, 16'h0001);
    chk("sync_state", 16'h0001, sync_state);
    for (i = 0; i < 200 && sync_state !== `SCB_SYNC_LOST; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("sync expiry window", 1'b1, i > 30 && i < 70);
    op(1'b1, `SCB_A_FW_SCREEN, 16'h0002); chk("fw_screen_on", 1'b1, fw_screen_on);
    for (i = 0; i < 200 && fw_screen_on !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("fw screen window", 1'b1, i > 10 && i < 60);
    v = 16'($random(seed));
    op(1'b1, `SCB_A_TEXT0, v); chk("custom_text", v, custom_text[63:48]);
    op(1'b1, `SCB_A_BACKLIGHT, v); chk("backlight", v, backlight);
    // the cast keeps the inversion to 16 bits inside the 64-bit compare
    op(1'b1, `SCB_A_END_LAYOUT, ~v); chk("end_layout", 16'(~v), end_layout);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verilog/scb_ctrl_end.sv
// controller end: issues one register access at a time on the link
// assumes the user holds a request until op_ready is seen
`timescale 1ns/1ps
`default_nettype none
`include "scb_defs.svh"
module scb_ctrl_end (
  scb_link_if.host link,
  input wire logic op_valid,
  input wire logic op_write,
  input wire logic [15:0] op_addr,
  input wire logic [15:0] op_wdata,
  output logic op_ready,
  output logic op_done,
  output logic op_err,
  output logic [15:0] op_rdata
);
  import scb_pkg::*;

  localparam logic [15:0] GAP = 16'(`SCB_GAP_CYCLES);

  scb_host_state_t s_reg;
  scb_host_state_t s_next;
  logic gap_tick;

  // silence before every request, one frame gap
  scb_timer #(.W(16), .PERIOD(GAP)) u_gap (
    .sys_clk(link.sys_clk),
    .rst_n(link.rst_n),
    .run(s_reg.fsm == SCB_H_GAP),
    .restart(s_reg.fsm != SCB_H_GAP),
    .tick(gap_tick)
  );

  assign op_ready = s_reg.fsm == SCB_H_IDLE;

  // idle -> gap -> request -> wait for answer
  always_comb begin
    s_next = s_reg;
    s_next.req_valid = 1'b0;
    s_next.done = 1'b0;
    unique case (s_reg.fsm)
      SCB_H_IDLE: begin
        if (op_valid) begin
          s_next.req_write = op_write;
          s_next.req_addr = op_addr;
          s_next.req_wdata = op_wdata;
          s_next.fsm = SCB_H_GAP;
        end
      end
      SCB_H_GAP: begin
        if (gap_tick) begin
          s_next.req_valid = 1'b1;
          s_next.fsm = SCB_H_WAIT;
        end
      end
      SCB_H_WAIT: begin
        if (link.rsp_valid) begin
          s_next.done = 1'b1;
          s_next.err = link.rsp_err;
          s_next.rdata = link.rsp_rdata;
          s_next.fsm = SCB_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link.sys_clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      s_reg <= '0;
      s_reg.fsm <= SCB_H_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.req_valid = s_reg.req_valid;
  assign link.req_write = s_reg.req_write;
  assign link.req_addr = s_reg.req_addr;
  assign link.req_wdata = s_reg.req_wdata;
  assign op_done = s_reg.done;
  assign op_err = s_reg.err;
  assign op_rdata = s_reg.rdata;
endmodule
`default_nettype wire

//--- verilog/scb_defs.svh
// constants of the signing control register bank: addresses, codes, timing
// assumes a 10 MHz system clock and a 115200 baud serial link
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH

`define SCB_A_CMD 16'hB7CB
`define SCB_A_STATUS 16'hB7CC
`define SCB_A_TZ 16'hB7CD
`define SCB_A_TIME_HI 16'hB7CE
`define SCB_A_TIME_LO 16'hB7CF
`define SCB_A_IN_LEN 16'hB7D0
`define SCB_A_OUT_LEN 16'hB7D1
`define SCB_A_SIG_LEN 16'hB7D2
`define SCB_A_SIG_FMT 16'hB7D3
`define SCB_A_ALGO 16'hB7D4
`define SCB_A_BACKLIGHT 16'hB7D5
`define SCB_A_ROW2 16'hB7D6
`define SCB_A_TEXT0 16'hB7D7
`define SCB_A_TEXT3 16'hB7DA
`define SCB_A_LABEL0 16'hB7DB
`define SCB_A_LABEL1 16'hB7DC
`define SCB_A_VERSION 16'hB7DD
`define SCB_A_CLEAR 16'hB7DE
`define SCB_A_SYNC 16'hB7DF
`define SCB_A_SYNC_TMO 16'hB7E0
`define SCB_A_TPRES 16'hB7E1
`define SCB_A_ADJUST 16'hB7E2
`define SCB_A_FW_SCREEN 16'hB7E3
`define SCB_A_END_LAYOUT 16'hB7E4

`define SCB_ST_UNINIT 16'h0000
`define SCB_ST_IDLE 16'h0001
`define SCB_ST_BUSY 16'h0002
`define SCB_ST_OK 16'h000F
`define SCB_ST_BAD_TIME 16'h0080
`define SCB_ST_BAD_CMD 16'h0082
`define SCB_ST_BAD_STATE 16'h0083
`define SCB_ST_ENG_LO 8'hF3

`define SCB_ALGO_ECDSA 16'h0004
`define SCB_VERSION_1_0 16'h0100
`define SCB_SYNC_LOST 16'h0000
`define SCB_TPRES_RESET 3'h0
`define SCB_ADJ_MAX 16'h0003

`define SCB_CLK_HZ 64'd10000000
`define SCB_BAUD 64'd115200
`define SCB_GAP_TENTH_CHARS 64'd35
`define SCB_BITS_PER_CHAR 64'd11
// least silence, rounded up to whole cycles
`define SCB_GAP_CYCLES \
  ((`SCB_GAP_TENTH_CHARS * `SCB_BITS_PER_CHAR * `SCB_CLK_HZ + 64'd10 * `SCB_BAUD - 64'd1) \
  / (64'd10 * `SCB_BAUD))
`define SCB_SECOND_S 64'd1
`define SCB_SECOND_CYCLES (`SCB_SECOND_S * `SCB_CLK_HZ)
`define SCB_MINUTE_S 64'd60
`define SCB_MINUTE_CYCLES (`SCB_MINUTE_S * `SCB_CLK_HZ)

`endif

//--- verilog/scb_link_if.sv
// word-level holding-register link between controller and meter
// assumes one shared clock; a request is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface scb_link_if (
  input wire logic sys_clk,
  input wire logic rst_n
);
  logic req_valid;
  logic req_write;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic rsp_valid;
  logic rsp_err;
  logic [15:0] rsp_rdata;

  modport dev (
    input sys_clk, rst_n, req_valid, req_write, req_addr, req_wdata,
    output rsp_valid, rsp_err, rsp_rdata
  );
  modport host (
    input sys_clk, rst_n, rsp_valid, rsp_err, rsp_rdata,
    output req_valid, req_write, req_addr, req_wdata
  );
endinterface
`default_nettype wire

//--- verilog/scb_meter_end.sv
// meter end: holding-register bank for the billing-signature controls
// assumes the signing engine and time keeper sit on the user-side ports
`timescale 1ns/1ps
`default_nettype none
`include "scb_defs.svh"
module scb_meter_end #(
  parameter logic [31:0] SECOND_CYCLES = 32'(`SCB_SECOND_CYCLES),
  parameter logic [31:0] MINUTE_CYCLES = 32'(`SCB_MINUTE_CYCLES),
  parameter logic [15:0] ALGO_VALUE = `SCB_ALGO_ECDSA
) (
  scb_link_if.dev link,
  input wire logic charge_active,
  input wire logic eng_busy,
  input wire logic eng_done,
  input wire logic [7:0] eng_result,
  input wire logic [15:0] in_msg_len,
  input wire logic [15:0] out_msg_len,
  input wire logic [15:0] sig_len,
  output logic cmd_strobe,
  output logic [15:0] cmd_word,
  output logic time_load,
  output logic [31:0] unix_time,
  output logic [15:0] utc_offset,
  output logic [2:0] time_utc_sel,
  output logic sig_base64,
  output logic adj_strobe,
  output logic [15:0] adj_seconds,
  output logic totals_clear,
  output logic fw_screen_on,
  output logic [15:0] backlight,
  output logic [15:0] row2_mode,
  output logic [63:0] custom_text,
  output logic [31:0] custom_label,
  output logic [15:0] end_layout,
  output logic [15:0] sync_state
);
  import scb_pkg::*;

  localparam logic [15:0] GAP = 16'(`SCB_GAP_CYCLES);

  scb_dev_state_t s_reg;
  scb_dev_state_t s_next;
  logic gap_tick;
  logic sec_tick;
  logic min_tick;
  logic wr;
  logic [15:0] a;
  logic [15:0] d;

  // known command letters in the high byte
  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      8'h42, 8'h45, 8'h4C, 8'h52, 8'h41, 8'h50, 8'h43, 8'h58,
      8'h54, 8'h53, 8'h72, 8'h66, 8'h68, 8'h69: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction

  // read-only words refuse writes
  function automatic logic is_ro(input logic [15:0] ad);
    is_ro = (ad == `SCB_A_STATUS) || (ad == `SCB_A_IN_LEN) || (ad == `SCB_A_OUT_LEN) ||
      (ad == `SCB_A_SIG_LEN) || (ad == `SCB_A_ALGO) || (ad == `SCB_A_VERSION);
  endfunction

  function automatic logic mapped(input logic [15:0] ad);
    mapped = (ad >= `SCB_A_CMD) && (ad <= `SCB_A_END_LAYOUT);
  endfunction

  // link silence: a frame gap counted from the last answered request
  scb_timer #(.W(16), .PERIOD(GAP)) u_gap (
    .sys_clk(link.sys_clk),
    .rst_n(link.rst_n),
    .run(!s_reg.gap_ok),
    .restart(link.req_valid && s_reg.gap_ok),
    .tick(gap_tick)
  );

  // seconds for the firmware screen
  scb_timer #(.W(32), .PERIOD(SECOND_CYCLES)) u_sec (
    .sys_clk(link.sys_clk),
    .rst_n(link.rst_n),
    .run(s_reg.fw_secs != 16'h0000),
    .restart(1'b0),
    .tick(sec_tick)
  );

  // minutes since the controller last set sync state
  scb_timer #(.W(32), .PERIOD(MINUTE_CYCLES)) u_min (
    .sys_clk(link.sys_clk),
    .rst_n(link.rst_n),
    .run(s_reg.sync_state != `SCB_SYNC_LOST),
    .restart(wr && (a == `SCB_A_SYNC)),
    .tick(min_tick)
  );

  // requests inside the silence are dropped, no answer is given
  assign wr = link.req_valid && link.req_write && s_reg.gap_ok;
  assign a = link.req_addr;
  assign d = link.req_wdata;

  // next state: writes, status, timers
  always_comb begin
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_err = 1'b0;
    s_next.cmd_pulse = 1'b0;
    s_next.time_pulse = 1'b0;
    s_next.clr_pulse = 1'b0;
    s_next.adj_pulse = 1'b0;
    if (gap_tick) begin
      s_next.gap_ok = 1'b1;
    end
    if (link.req_valid && s_reg.gap_ok) begin
      s_next.gap_ok = 1'b0;
      s_next.rsp_valid = 1'b1;
      s_next.rsp_err = !mapped(a);
    end
    if (!charge_active) begin
      s_next.adj_used = 1'b0;
    end
    // engine progress; a write outcome below overrides it in the same cycle
    if (eng_done) begin
      s_next.status = {8'h00, eng_result};
    end else if (eng_busy && s_reg.status != `SCB_ST_BUSY) begin
      s_next.status = `SCB_ST_BUSY;
    end
    if (sec_tick) begin
      s_next.fw_secs = s_reg.fw_secs - 16'h0001;
    end
    // a minute tick only counts while sync is held
    if (min_tick) begin
      if (s_reg.min_cnt + 16'h0001 >= s_reg.sync_tmo && s_reg.sync_tmo != 16'h0000) begin
        s_next.sync_state = `SCB_SYNC_LOST;
        s_next.min_cnt = 16'h0000;
      end else begin
        s_next.min_cnt = s_reg.min_cnt + 16'h0001;
      end
    end
    if (wr) begin
      if (is_ro(a)) begin
        s_next.status = `SCB_ST_BAD_CMD;
      end else begin
        unique case (a)
          `SCB_A_CMD: begin
            s_next.cmd = d;
            if (!s_reg.time_valid) begin
              s_next.status = `SCB_ST_BAD_TIME;
            end else if (!cmd_known(d[15:8])) begin
              s_next.status = `SCB_ST_BAD_CMD;
            end else if ((d[15:8] == 8'h42 || d[15:8] == 8'h69) == charge_active &&
                d[15:8] != 8'h66) begin
              s_next.status = `SCB_ST_BAD_STATE;
            end else begin
              s_next.cmd_pulse = 1'b1;
              s_next.status = `SCB_ST_BUSY;
            end
          end
          `SCB_A_TZ: s_next.tz = d;
          `SCB_A_TIME_HI, `SCB_A_TIME_LO: begin
            if (charge_active) begin
              s_next.status = `SCB_ST_BAD_STATE;
            end else if (a == `SCB_A_TIME_HI) begin
              s_next.time_hi = d;
            end else begin
              s_next.time_lo = d;
              s_next.time_pulse = 1'b1;
              s_next.time_valid = 1'b1;
              if (s_reg.status == `SCB_ST_UNINIT) begin
                s_next.status = `SCB_ST_IDLE;
              end
            end
          end
          `SCB_A_SIG_FMT: s_next.sig_fmt = d;
          `SCB_A_BACKLIGHT: s_next.backlight = d;
          `SCB_A_ROW2: s_next.row2 = d;
          `SCB_A_TEXT0, `SCB_A_TEXT0 + 16'h0001, `SCB_A_TEXT0 + 16'h0002, `SCB_A_TEXT3:
            s_next.text[16*(3-(a-`SCB_A_TEXT0)) +: 16] = d;
          `SCB_A_LABEL0: s_next.label[31:16] = d;
          `SCB_A_LABEL1: s_next.label[15:0] = d;
          `SCB_A_CLEAR: s_next.clr_pulse = d[0];
          `SCB_A_SYNC: begin
            s_next.sync_state = d;
            s_next.min_cnt = 16'h0000;
          end
          `SCB_A_SYNC_TMO: s_next.sync_tmo = d;
          `SCB_A_TPRES: s_next.tpres = d[2:0];
          `SCB_A_ADJUST: begin
            // signed seconds, magnitude at most three, once per charge
            if (!charge_active || s_reg.adj_used ||
                ($signed(d) > $signed(`SCB_ADJ_MAX)) || ($signed(d) < -$signed(`SCB_ADJ_MAX))) begin
              s_next.status = `SCB_ST_BAD_STATE;
            end else begin
              s_next.adj_used = 1'b1;
              s_next.adj_pulse = 1'b1;
              s_next.adj_val = d;
            end
          end
          `SCB_A_FW_SCREEN: s_next.fw_secs = d;
          `SCB_A_END_LAYOUT: s_next.end_layout = d;
          default: ;
        endcase
      end
    end
    // read data, held from the taken request
    if (link.req_valid && s_reg.gap_ok && !link.req_write) begin
      unique case (a)
        `SCB_A_CMD: s_next.rdata = s_reg.cmd;
        `SCB_A_STATUS: s_next.rdata = s_reg.status;
        `SCB_A_TZ: s_next.rdata = s_reg.tz;
        `SCB_A_TIME_HI: s_next.rdata = s_reg.time_hi;
        `SCB_A_TIME_LO: s_next.rdata = s_reg.time_lo;
        `SCB_A_IN_LEN: s_next.rdata = in_msg_len;
        `SCB_A_OUT_LEN: s_next.rdata = out_msg_len;
        `SCB_A_SIG_LEN: s_next.rdata = sig_len;
        `SCB_A_SIG_FMT: s_next.rdata = s_reg.sig_fmt;
        `SCB_A_ALGO: s_next.rdata = ALGO_VALUE;
        `SCB_A_BACKLIGHT: s_next.rdata = s_reg.backlight;
        `SCB_A_ROW2: s_next.rdata = s_reg.row2;
        `SCB_A_TEXT0, `SCB_A_TEXT0 + 16'h0001, `SCB_A_TEXT0 + 16'h0002, `SCB_A_TEXT3:
          s_next.rdata = s_reg.text[16*(3-(a-`SCB_A_TEXT0)) +: 16];
        `SCB_A_LABEL0: s_next.rdata = s_reg.label[31:16];
        `SCB_A_LABEL1: s_next.rdata = s_reg.label[15:0];
        `SCB_A_VERSION: s_next.rdata = `SCB_VERSION_1_0;
        `SCB_A_SYNC: s_next.rdata = s_reg.sync_state;
        `SCB_A_SYNC_TMO: s_next.rdata = s_reg.sync_tmo;
        `SCB_A_TPRES: s_next.rdata = {13'h0000, s_reg.tpres};
        `SCB_A_END_LAYOUT: s_next.rdata = s_reg.end_layout;
        default: s_next.rdata = 16'h0000; // write-only and unmapped read zero
      endcase
    end
  end

  // presentation selections come out of reset as local time
  always_ff @(posedge link.sys_clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      s_reg <= '0;
      s_reg.status <= `SCB_ST_UNINIT;
      s_reg.tpres <= `SCB_TPRES_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.rsp_valid = s_reg.rsp_valid;
  assign link.rsp_err = s_reg.rsp_err;
  assign link.rsp_rdata = s_reg.rdata;
  assign cmd_strobe = s_reg.cmd_pulse;
  assign cmd_word = s_reg.cmd;
  assign time_load = s_reg.time_pulse;
  assign unix_time = {s_reg.time_hi, s_reg.time_lo};
  assign utc_offset = s_reg.tz;
  assign time_utc_sel = s_reg.tpres;
  assign sig_base64 = s_reg.sig_fmt[0];
  assign adj_strobe = s_reg.adj_pulse;
  assign adj_seconds = s_reg.adj_val;
  assign totals_clear = s_reg.clr_pulse;
  assign fw_screen_on = s_reg.fw_secs != 16'h0000;
  assign backlight = s_reg.backlight;
  assign row2_mode = s_reg.row2;
  assign custom_text = s_reg.text;
  assign custom_label = s_reg.label;
  assign end_layout = s_reg.end_layout;
  assign sync_state = s_reg.sync_state;
endmodule
`default_nettype wire

//--- verilog/scb_pkg.sv
// types shared by both ends of the signing control link
// assumes nothing beyond the constants header
package scb_pkg;
  // device end state, registered as one word
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] status;
    logic [15:0] tz;
    logic [15:0] time_hi;
    logic [15:0] time_lo;
    logic [15:0] sig_fmt;
    logic [15:0] backlight;
    logic [15:0] row2;
    logic [63:0] text;
    logic [31:0] label;
    logic [15:0] sync_state;
    logic [15:0] sync_tmo;
    logic [15:0] end_layout;
    logic [15:0] fw_secs;
    logic [15:0] min_cnt;
    logic [15:0] adj_val;
    logic [2:0] tpres;
    logic adj_used;
    logic time_valid;
    logic gap_ok;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rdata;
    logic cmd_pulse;
    logic time_pulse;
    logic clr_pulse;
    logic adj_pulse;
  } scb_dev_state_t;

  typedef enum logic [2:0] {
    SCB_H_IDLE = 3'b001,
    SCB_H_GAP = 3'b010,
    SCB_H_WAIT = 3'b100
  } scb_host_fsm_t;

  typedef struct packed {
    scb_host_fsm_t fsm;
    logic req_valid;
    logic req_write;
    logic [15:0] req_addr;
    logic [15:0] req_wdata;
    logic done;
    logic err;
    logic [15:0] rdata;
  } scb_host_state_t;
endpackage

//--- verilog/scb_timer.sv
// free period timer: one-cycle tick every PERIOD cycles while running
// assumes restart is synchronous; restart wins over run
`timescale 1ns/1ps
`default_nettype none
module scb_timer #(
  parameter int W = 32,
  parameter logic [W-1:0] PERIOD = 32'd10
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  output logic tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // count up to one below the period, then wrap with a tick
  always_comb begin
    cnt_next = cnt_reg;
    tick = 1'b0;
    if (restart) begin
      cnt_next = '0;
    end else if (run) begin
      if (cnt_reg == PERIOD - W'(1)) begin
        cnt_next = '0;
        tick = 1'b1;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire
